// ==== logic/tmcc_core.sv ====
// Timer core with compare, capture, output pair and AXI4-Lite slave
`timescale 1ns/1ps
// How it works
// - Counter equal to comparator raises interrupt, may clear counter, drive output.
// - Three-bit select picks system ratio, high clock, sub clock or pin.
// - Pin clock counts on rising or falling edge as selected.
// - Separate interrupt sources for comparator A and comparator P matches.
// - Clock pin also triggers a pulse in single pulse mode.
// - Capture pin edge chosen by two bits: rising, falling or both.
// - Second output pin always carries inverse of primary output.
// - Compare output mode sets, clears or toggles output on match.
// - PWM waveform appears on the same output pin pair.
// - Low byte write of compare pair only fills the holding buffer.
// - High byte write stores high byte and copies buffer into low.
// - High byte read returns high byte and latches live low byte.
// - Low byte read returns the holding buffer, not live value.
// - Ten-bit counter; A compares all bits, P top three bits.
// - Counter clears on enable rise, overflow or enabled compare match.
module tmcc_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire tmcc_pkg::tmcc_axi_m2s_s axi_in,
    output tmcc_pkg::tmcc_axi_s2m_s axi_out,
    input wire logic timer_ext_clock_pin,
    input wire logic capture_input_pin,
    output logic timer_output_pin,
    output logic timer_output_inverted_pin,
    output logic irq
);

    // **********************************
    // State
    // **********************************
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [1:0] capctl;
        logic [2:0] stat;
        logic [2:0] mask;
        logic [9:0] cnt;
        logic [9:0] compare_a_value;
        logic [9:0] cap;
        logic [7:0] lbuf;
        logic en_d;
        logic busy;
        logic out;
        logic outb;
        logic irq;
        logic [2:0] cap_sy;
        logic aw_h;
        logic [7:0] aw_a;
        logic w_h;
        logic [7:0] w_d;
        logic w_s;
        tmcc_pkg::tmcc_axi_s2m_s bus;
    } tmcc_state_s;

    tmcc_state_s st_r, st_nxt;
    tmcc_pkg::tmcc_mode_e mode;
    logic tick, ext_rise, en, run, en_rise;
    logic match_a, match_p, cap_ev, cap_set;
    logic rd_go, wr_go, rd_stat, clr_hit, oc, pol;
    logic [1:0] io;
    logic [2:0] period_compare_value;
    logic [9:0] cnt_inc;

    function automatic logic mapped(input logic [7:0] a);
        return a inside {tmcc_pkg::OFF_CTRL0, tmcc_pkg::OFF_CTRL1,
                         tmcc_pkg::OFF_CNT_LO, tmcc_pkg::OFF_CNT_HI,
                         tmcc_pkg::OFF_CMPA_LO, tmcc_pkg::OFF_CMPA_HI,
                         tmcc_pkg::OFF_STAT, tmcc_pkg::OFF_MASK,
                         tmcc_pkg::OFF_CAPCTL, tmcc_pkg::OFF_CAP};
    endfunction

    // **********************************
    // Clock source
    // **********************************
    // source select
    tmcc_clk_src u_clk_src (
        .aclk(aclk),
        .aresetn(aresetn),
        .sel(st_r.ctrl0[tmcc_pkg::CKSEL_LSB+:3]),
        .ext_pin(timer_ext_clock_pin),
        .tick(tick),
        .ext_rise(ext_rise)
    );

    // **********************************
    // Decode
    // **********************************
    assign mode = tmcc_pkg::tmcc_mode_e'(st_r.ctrl1[tmcc_pkg::MODE_LSB+:2]);
    assign io = st_r.ctrl1[tmcc_pkg::IO_LSB+:2];
    assign oc = st_r.ctrl1[tmcc_pkg::OC_BIT];
    assign pol = st_r.ctrl1[tmcc_pkg::POL_BIT];
    assign period_compare_value = st_r.ctrl0[tmcc_pkg::PERIOD_COMPARE_VALUE_LSB+:3];
    assign en = st_r.ctrl0[tmcc_pkg::EN_BIT];
    assign en_rise = en && !st_r.en_d;
    // Single pulse mode counts only while a pulse is out
    assign run = en && !st_r.ctrl0[tmcc_pkg::PAUSE_BIT]
                 && (mode != tmcc_pkg::MODE_SPULSE || st_r.busy);
    assign cnt_inc = st_r.cnt + 10'h001;
    assign match_a = tick && run && (st_r.cnt == st_r.compare_a_value);
    // P on top three bits; zero means full overflow
    assign match_p = tick && run && (cnt_inc == {period_compare_value, 7'h00});
    assign clr_hit = st_r.ctrl1[tmcc_pkg::CCLR_BIT] ? match_a : match_p;

    always_comb begin
        unique case (st_r.capctl)
            2'h0: cap_ev = st_r.cap_sy[1] && !st_r.cap_sy[2];
            2'h1: cap_ev = !st_r.cap_sy[1] && st_r.cap_sy[2];
            2'h2: cap_ev = st_r.cap_sy[1] != st_r.cap_sy[2];
            2'h3: cap_ev = 1'b0;
        endcase
    end
    assign cap_set = cap_ev && en;

    assign rd_go = axi_in.arvalid && st_r.bus.arready;
    assign wr_go = st_r.aw_h && st_r.w_h && !st_r.bus.bvalid;
    assign rd_stat = rd_go && axi_in.araddr == tmcc_pkg::OFF_STAT;

    // **********************************
    // Next state
    // **********************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.cap_sy = {st_r.cap_sy[1:0], capture_input_pin};
        st_nxt.en_d = en;

        if (en_rise) begin
            st_nxt.cnt = 10'h000;
        end else if (tick && run) begin
            st_nxt.cnt = clr_hit ? 10'h000 : cnt_inc;
        end

        if (en_rise) begin
            st_nxt.out = oc;
            st_nxt.busy = 1'b0;
        end else begin
            unique case (mode)
                tmcc_pkg::MODE_CMP: begin
                    if (match_a) begin
                        unique case (io)
                            2'h0: ;
                            2'h1: st_nxt.out = 1'b0;
                            2'h2: st_nxt.out = 1'b1;
                            2'h3: st_nxt.out = !st_r.out;
                        endcase
                    end
                end
                tmcc_pkg::MODE_PWM: begin
                    if (en) begin
                        unique case (io)
                            2'h0: st_nxt.out = pol;
                            2'h1: st_nxt.out = !pol;
                            2'h2: st_nxt.out = (st_r.cnt < st_r.compare_a_value) ^ pol;
                            2'h3: ;
                        endcase
                    end
                end
                tmcc_pkg::MODE_SPULSE: begin
                    if (en && !st_r.busy && ext_rise) begin
                        st_nxt.busy = 1'b1;
                        st_nxt.out = !oc;
                        st_nxt.cnt = 10'h000;
                    end else if (st_r.busy && match_a) begin
                        st_nxt.busy = 1'b0;
                        st_nxt.out = oc;
                    end
                end
                tmcc_pkg::MODE_TIMER: ;
            endcase
        end
        st_nxt.outb = !st_nxt.out;

        if (cap_set) begin
            st_nxt.cap = st_r.cnt;
        end

        // Write channels held until both halves are in
        if (axi_in.awvalid && st_r.bus.awready) begin
            st_nxt.aw_h = 1'b1;
            st_nxt.aw_a = axi_in.awaddr;
        end
        if (axi_in.wvalid && st_r.bus.wready) begin
            st_nxt.w_h = 1'b1;
            st_nxt.w_d = axi_in.wdata[7:0];
            st_nxt.w_s = axi_in.wstrb[0];
        end
        if (st_r.bus.bvalid && axi_in.bready) begin
            st_nxt.bus.bvalid = 1'b0;
        end
        if (wr_go) begin
            st_nxt.aw_h = 1'b0;
            st_nxt.w_h = 1'b0;
            st_nxt.bus.bvalid = 1'b1;
            st_nxt.bus.bresp = mapped(st_r.aw_a) ? tmcc_pkg::RESP_OKAY
                                                 : tmcc_pkg::RESP_SLVERR;
            if (st_r.w_s) begin
                case (st_r.aw_a)
                    tmcc_pkg::OFF_CTRL0: st_nxt.ctrl0 = st_r.w_d;
                    tmcc_pkg::OFF_CTRL1: st_nxt.ctrl1 = st_r.w_d;
                    tmcc_pkg::OFF_CMPA_LO: st_nxt.lbuf = st_r.w_d;
                    tmcc_pkg::OFF_CMPA_HI: begin
                        st_nxt.compare_a_value = {st_r.w_d[1:0], st_r.lbuf};
                    end
                    tmcc_pkg::OFF_MASK: st_nxt.mask = st_r.w_d[2:0];
                    tmcc_pkg::OFF_CAPCTL: st_nxt.capctl = st_r.w_d[1:0];
                    default: ;
                endcase
            end
        end

        if (st_r.bus.rvalid && axi_in.rready) begin
            st_nxt.bus.rvalid = 1'b0;
        end
        // Read after write so a same-cycle high read owns the buffer
        if (rd_go) begin
            st_nxt.bus.rvalid = 1'b1;
            st_nxt.bus.rresp = mapped(axi_in.araddr) ? tmcc_pkg::RESP_OKAY
                                                     : tmcc_pkg::RESP_SLVERR;
            st_nxt.bus.rdata = 32'h0000_0000;
            case (axi_in.araddr)
                tmcc_pkg::OFF_CTRL0: st_nxt.bus.rdata[7:0] = st_r.ctrl0;
                tmcc_pkg::OFF_CTRL1: st_nxt.bus.rdata[7:0] = st_r.ctrl1;
                tmcc_pkg::OFF_CNT_LO, tmcc_pkg::OFF_CMPA_LO: begin
                    st_nxt.bus.rdata[7:0] = st_r.lbuf;
                end
                tmcc_pkg::OFF_CNT_HI: begin
                    st_nxt.bus.rdata[1:0] = st_r.cnt[9:8];
                    st_nxt.lbuf = st_r.cnt[7:0];
                end
                tmcc_pkg::OFF_CMPA_HI: begin
                    st_nxt.bus.rdata[1:0] = st_r.compare_a_value[9:8];
                    st_nxt.lbuf = st_r.compare_a_value[7:0];
                end
                tmcc_pkg::OFF_STAT: st_nxt.bus.rdata[2:0] = st_r.stat;
                tmcc_pkg::OFF_MASK: st_nxt.bus.rdata[2:0] = st_r.mask;
                tmcc_pkg::OFF_CAPCTL: st_nxt.bus.rdata[1:0] = st_r.capctl;
                tmcc_pkg::OFF_CAP: st_nxt.bus.rdata[9:0] = st_r.cap;
                default: ;
            endcase
        end

        // sticky flags, a new event beats the read clear
        st_nxt.stat = (rd_stat ? 3'h0 : st_r.stat)
                      | {cap_set, match_p, match_a};
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

        st_nxt.bus.awready = !st_nxt.aw_h && !st_nxt.bus.bvalid;
        st_nxt.bus.wready = !st_nxt.w_h && !st_nxt.bus.bvalid;
        st_nxt.bus.arready = !st_nxt.bus.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.ctrl0 <= tmcc_pkg::CTRL_RST;
            st_r.ctrl1 <= tmcc_pkg::CTRL_RST;
            st_r.mask <= tmcc_pkg::MASK_RST;
            st_r.outb <= tmcc_pkg::OUTB_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // **********************************
    // Outputs
    // **********************************
    assign axi_out = st_r.bus;
    assign timer_output_pin = st_r.out;
    assign timer_output_inverted_pin = st_r.outb;
    assign irq = st_r.irq;

    // **********************************
    // Checks
    // **********************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence lo_wr_s;
        wr_go && st_r.w_s && st_r.aw_a == tmcc_pkg::OFF_CMPA_LO;
    endsequence
    sequence hi_wr_s;
        wr_go && st_r.w_s && st_r.aw_a == tmcc_pkg::OFF_CMPA_HI;
    endsequence
    sequence cnt_hi_rd_s;
        rd_go && axi_in.araddr == tmcc_pkg::OFF_CNT_HI;
    endsequence

    match_clear_a:
        assert property (match_a && st_r.ctrl1[tmcc_pkg::CCLR_BIT]
                         && !en_rise |=> st_r.cnt == 10'h000)
        else $error("counter not cleared by comparator A match");
    ext_hold_a:
        assert property ($stable(timer_ext_clock_pin)[*4] ##0
                         (st_r.ctrl0[tmcc_pkg::CKSEL_LSB+:3] == 3'h6
                          && !en_rise) |=> $stable(st_r.cnt))
        else $error("counter moved without a pin edge");
    p_flag_a:
        assert property (match_p |=> st_r.stat[tmcc_pkg::INT_P])
        else $error("comparator P flag not set");
    pulse_start_a:
        assert property (mode == tmcc_pkg::MODE_SPULSE && en && !st_r.busy
                         && ext_rise && !en_rise
                         |=> st_r.busy && timer_output_pin == !$past(oc))
        else $error("single pulse not started by trigger");
    capture_a:
        assert property (cap_set |=> st_r.cap == $past(st_r.cnt)
                         && st_r.stat[tmcc_pkg::INT_CAP])
        else $error("capture value or flag wrong");
    inv_pin_a:
        assert property (timer_output_inverted_pin == !timer_output_pin)
        else $error("inverted pin not inverse of output");
    cmp_toggle_a:
        assert property (mode == tmcc_pkg::MODE_CMP && match_a && io == 2'h3
                         && !en_rise |=> timer_output_pin != $past(st_r.out))
        else $error("toggle on match missing");
    pwm_out_a:
        assert property (mode == tmcc_pkg::MODE_PWM && en && io == 2'h2
                         && !en_rise |=> timer_output_pin ==
                         (($past(st_r.cnt) < $past(st_r.compare_a_value)) ^ $past(pol)))
        else $error("PWM level wrong");
    lo_write_a:
        assert property (lo_wr_s |=> $stable(st_r.compare_a_value)
                         && st_r.lbuf == $past(st_r.w_d))
        else $error("low write touched compare value");
    hi_write_a:
        assert property (hi_wr_s |=> st_r.compare_a_value ==
                         {$past(st_r.w_d[1:0]), $past(st_r.lbuf)})
        else $error("high write did not merge buffer");
    hi_read_a:
        assert property (cnt_hi_rd_s |=> st_r.lbuf == $past(st_r.cnt[7:0])
                         && axi_out.rdata[1:0] == $past(st_r.cnt[9:8]))
        else $error("high read did not latch low byte");
    p_top_bits_a:
        assert property (match_p |-> st_r.cnt[6:0] == 7'h7f)
        else $error("comparator P matched off a 128 boundary");
    en_clear_a:
        assert property (en_rise |=> st_r.cnt == 10'h000)
        else $error("counter not cleared on enable");
    sticky_a:
        assert property (st_r.stat[tmcc_pkg::INT_A] && !rd_stat
                         |=> st_r.stat[tmcc_pkg::INT_A])
        else $error("comparator A flag dropped without read");
endmodule

// ==== include/tmcc_pkg.sv ====
// Shared constants and types of the timer core
package tmcc_pkg;

    // **********************************
    // Timing
    // **********************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SUB_PERIOD_NS = 30518;
    localparam int SUB_CYCLES = SUB_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [11:0] SUB_RELOAD = 12'(SUB_CYCLES - 1);
    localparam logic [5:0] DIV4_M = 6'h03;
    localparam logic [5:0] DIV16_M = 6'h0f;
    localparam logic [5:0] DIV64_M = 6'h3f;

    // **********************************
    // Register offsets
    // **********************************
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_CNT_LO = 8'h08;
    localparam logic [7:0] OFF_CNT_HI = 8'h0c;
    localparam logic [7:0] OFF_CMPA_LO = 8'h10;
    localparam logic [7:0] OFF_CMPA_HI = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    localparam logic [7:0] OFF_MASK = 8'h1c;
    localparam logic [7:0] OFF_CAPCTL = 8'h20;
    localparam logic [7:0] OFF_CAP = 8'h24;

    // **********************************
    // Field positions and reset values
    // **********************************
    localparam int PAUSE_BIT = 7;
    localparam int CKSEL_LSB = 4;
    localparam int EN_BIT = 3;
    localparam int PERIOD_COMPARE_VALUE_LSB = 0;
    localparam int MODE_LSB = 6;
    localparam int IO_LSB = 4;
    localparam int OC_BIT = 3;
    localparam int POL_BIT = 2;
    localparam int CCLR_BIT = 0;
    localparam int INT_A = 0;
    localparam int INT_P = 1;
    localparam int INT_CAP = 2;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic OUTB_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // **********************************
    // Types
    // **********************************
    typedef enum logic [1:0] {
        MODE_CMP,
        MODE_SPULSE,
        MODE_PWM,
        MODE_TIMER
    } tmcc_mode_e;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } tmcc_axi_m2s_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tmcc_axi_s2m_s;

endpackage

// ==== logic/tmcc_clk_src.sv ====
// Counter clock source selection and external edge detection
`timescale 1ns/1ps
module tmcc_clk_src (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] sel,
    input wire logic ext_pin,
    output logic tick,
    output logic ext_rise
);
    logic [5:0] div_r, div_nxt;
    logic [11:0] sub_r, sub_nxt;
    logic [2:0] sy_r, sy_nxt;
    logic ext_fall;

    always_comb begin
        div_nxt = div_r + 6'h01;
        sub_nxt = (sub_r == 12'h000) ? tmcc_pkg::SUB_RELOAD
                                     : sub_r - 12'h001;
        sy_nxt = {sy_r[1:0], ext_pin};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r <= 6'h00;
            sub_r <= 12'h000;
            sy_r <= 3'h0;
        end else begin
            div_r <= div_nxt;
            sub_r <= sub_nxt;
            sy_r <= sy_nxt;
        end
    end

    // Edges seen only past the second flop
    assign ext_rise = sy_r[1] && !sy_r[2];
    assign ext_fall = !sy_r[1] && sy_r[2];

    // The high clock is taken as the system clock here
    always_comb begin
        unique case (sel)
            3'h0: tick = (div_r & tmcc_pkg::DIV4_M) == tmcc_pkg::DIV4_M;
            3'h1: tick = 1'b1;
            3'h2: tick = (div_r & tmcc_pkg::DIV16_M) == tmcc_pkg::DIV16_M;
            3'h3: tick = (div_r & tmcc_pkg::DIV64_M) == tmcc_pkg::DIV64_M;
            3'h4, 3'h5: tick = (sub_r == 12'h000);
            3'h6: tick = ext_rise;
            3'h7: tick = ext_fall;
        endcase
    end
endmodule

// ==== test/tmcc_pin_model.sv ====
// Far-side model of the timer clock and capture pins
`timescale 1ns/1ps
module tmcc_pin_model (
    input wire logic aclk,
    output logic ext_clk,
    output logic cap
);
    initial begin
        ext_clk = 1'b0;
        cap = 1'b0;
    end
    // whole pulses give one edge of each kind
    task automatic pulses(input int n, input int half);
        for (int i = 0; i < n; i++) begin
            repeat (half) @(posedge aclk);
            ext_clk <= 1'b1;
            repeat (half) @(posedge aclk);
            ext_clk <= 1'b0;
        end
    endtask
    task automatic set_cap(input logic v);
        @(posedge aclk);
        cap <= v;
    endtask
endmodule

// ==== test/tmcc_core_tb_top.sv ====
// Self-checking bench of the timer core
`timescale 1ns/1ps
module tmcc_core_tb_top;
    logic aclk;
    logic aresetn;
    tmcc_pkg::tmcc_axi_m2s_s m;
    tmcc_pkg::tmcc_axi_s2m_s s;
    logic tp, tpb, irq, ext_clk, cap;
    logic [31:0] d;
    logic [1:0] r;
    int failures = 0;
    int n_checks = 0;
    tmcc_core tmcc_core_inst (.aclk(aclk), .aresetn(aresetn), .axi_in(m),
        .axi_out(s), .timer_ext_clock_pin(ext_clk),
        .capture_input_pin(cap), .timer_output_pin(tp),
        .timer_output_inverted_pin(tpb), .irq(irq));
    tmcc_pin_model tmcc_pin_model_inst (.aclk(aclk), .ext_clk(ext_clk),
        .cap(cap));
    // **********************************
    // Helpers
    // **********************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bit done;
        done = 0;
        @(posedge aclk);
        m.awvalid <= 1'b1;
        m.awaddr <= a;
        m.wvalid <= 1'b1;
        m.wdata <= {24'h0, v};
        m.wstrb <= 4'h1;
        m.bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (m.awvalid && s.awready) m.awvalid <= 1'b0;
            if (m.wvalid && s.wready) m.wvalid <= 1'b0;
            if (s.bvalid) begin
                r = s.bresp;
                m.bready <= 1'b0;
                done = 1;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a);
        bit done;
        done = 0;
        @(posedge aclk);
        m.arvalid <= 1'b1;
        m.araddr <= a;
        m.rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (m.arvalid && s.arready) m.arvalid <= 1'b0;
            if (s.rvalid) begin
                d = s.rdata;
                r = s.rresp;
                m.rready <= 1'b0;
                done = 1;
            end
        end
    endtask
    task automatic wait_irq();
        while (irq !== 1'b1) @(posedge aclk);
    endtask
    task automatic set_cmpa(input logic [9:0] v);
        wr(tmcc_pkg::OFF_CMPA_LO, v[7:0]);
        wr(tmcc_pkg::OFF_CMPA_HI, {6'h0, v[9:8]});
    endtask
    // **********************************
    // Scenarios
    // **********************************
    task automatic t_reset();
        chk({tp, tpb, irq}, 3'h2);
        rd(tmcc_pkg::OFF_CTRL0);
        chk(d, 32'h0);
        rd(8'h28);
        chk(d, 32'h0);
        chk({30'h0, r}, 32'h2);
        wr(8'h28, 8'h55);
        chk({30'h0, r}, 32'h2);
    endtask
    task automatic t_pair();
        wr(tmcc_pkg::OFF_CMPA_LO, 8'h5a);
        rd(tmcc_pkg::OFF_CMPA_HI);
        chk(d, 32'h0);
        rd(tmcc_pkg::OFF_CMPA_LO);
        chk(d, 32'h0);
        set_cmpa(10'h25a);
        rd(tmcc_pkg::OFF_CMPA_HI);
        chk(d, 32'h2);
        rd(tmcc_pkg::OFF_CMPA_LO);
        chk(d, 32'h5a);
    endtask
    task automatic t_match_a();
        set_cmpa(10'h010);
        wr(tmcc_pkg::OFF_CTRL1, 8'h31);
        wr(tmcc_pkg::OFF_MASK, 8'h01);
        wr(tmcc_pkg::OFF_CTRL0, 8'h18);
        wait_irq();
        chk({tp, tpb}, 2'h2);
        wr(tmcc_pkg::OFF_CTRL0, 8'h10);
        rd(tmcc_pkg::OFF_STAT);
        chk(d, 32'h1);
        rd(tmcc_pkg::OFF_STAT);
        chk(d, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rd(tmcc_pkg::OFF_CNT_HI);
        chk(d, 32'h0);
        rd(tmcc_pkg::OFF_CNT_LO);
        chk({31'h0, d[7:0] <= 8'h10}, 32'h1);
    endtask
    task automatic t_match_p();
        wr(tmcc_pkg::OFF_CTRL1, 8'hc0);
        wr(tmcc_pkg::OFF_MASK, 8'h02);
        wr(tmcc_pkg::OFF_CTRL0, 8'h19);
        wait_irq();
        rd(tmcc_pkg::OFF_STAT);
        chk(d & 32'h2, 32'h2);
        cyc(300);
        wr(tmcc_pkg::OFF_CTRL0, 8'h11);
        rd(tmcc_pkg::OFF_CNT_HI);
        chk(d, 32'h0);
        rd(tmcc_pkg::OFF_CNT_LO);
        chk({31'h0, d[7]}, 32'h0);
        wr(tmcc_pkg::OFF_MASK, 8'h00);
    endtask
    // Divided sources: about 260 system edges between enable and disable
    task automatic t_div();
        int lo;
        int hi;
        for (int k = 0; k < 4; k++) begin
            if (k != 1) begin
                lo = 256 >> ((k == 0) ? 2 : ((k == 2) ? 4 : 6));
                hi = lo + 2;
                wr(tmcc_pkg::OFF_CTRL0, {1'b0, 3'(k), 4'h8});
                cyc(256);
                wr(tmcc_pkg::OFF_CTRL0, {1'b0, 3'(k), 4'h0});
                rd(tmcc_pkg::OFF_CNT_HI);
                rd(tmcc_pkg::OFF_CNT_LO);
                chk({31'h0, (d >= lo) && (d <= hi)}, 32'h1);
            end
        end
    endtask
    task automatic t_ext();
        for (int k = 6; k < 8; k++) begin
            wr(tmcc_pkg::OFF_CTRL0, {1'b0, 3'(k), 4'h8});
            tmcc_pin_model_inst.pulses(5, 6);
            cyc(10);
            wr(tmcc_pkg::OFF_CTRL0, {1'b0, 3'(k), 4'h0});
            rd(tmcc_pkg::OFF_CNT_HI);
            rd(tmcc_pkg::OFF_CNT_LO);
            chk(d, 32'h5);
        end
    endtask
    task automatic t_capture();
        wr(tmcc_pkg::OFF_CTRL0, 8'h18);
        for (int c = 0; c < 3; c++) begin
            wr(tmcc_pkg::OFF_CAPCTL, 8'(c));
            rd(tmcc_pkg::OFF_STAT);
            tmcc_pin_model_inst.set_cap(1'b1);
            cyc(8);
            rd(tmcc_pkg::OFF_STAT);
            chk(d & 32'h4, (c != 1) ? 32'h4 : 32'h0);
            tmcc_pin_model_inst.set_cap(1'b0);
            cyc(8);
            rd(tmcc_pkg::OFF_STAT);
            chk(d & 32'h4, (c != 0) ? 32'h4 : 32'h0);
        end
        wr(tmcc_pkg::OFF_CTRL0, 8'h10);
    endtask
    task automatic t_pulse();
        set_cmpa(10'h040);
        wr(tmcc_pkg::OFF_CTRL1, 8'h40);
        wr(tmcc_pkg::OFF_CTRL0, 8'h18);
        chk({31'h0, tp}, 32'h0);
        tmcc_pin_model_inst.pulses(1, 5);
        chk({tp, tpb}, 2'h2);
        while (tp !== 1'b0) @(posedge aclk);
        chk({31'h0, tpb}, 32'h1);
        wr(tmcc_pkg::OFF_CTRL0, 8'h10);
    endtask
    task automatic t_pwm();
        int hi;
        int bad;
        hi = 0;
        bad = 0;
        set_cmpa(10'h020);
        wr(tmcc_pkg::OFF_CTRL1, 8'ha0);
        wr(tmcc_pkg::OFF_CTRL0, 8'h19);
        cyc(10);
        repeat (256) begin
            @(posedge aclk);
            if (tp === 1'b1) hi++;
            if (tpb !== ~tp) bad++;
        end
        chk(32'(hi), 32'd64);
        chk(32'(bad), 32'd0);
    endtask
    // **********************************
    // Clock, reset, sequence
    // **********************************
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        #500000;
        failures++;
        end_sim();
    end
    initial begin
        aresetn = 1'b0;
        m = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        cyc(2);
        t_reset();
        t_pair();
        t_match_a();
        t_match_p();
        t_div();
        t_ext();
        t_capture();
        t_pulse();
        t_pwm();
        end_sim();
    end
endmodule
